/* src/pli_pkg.sv */
// ****************************************************************
// pad level register package
// ****************************************************************
package pli_pkg;

  // ****************************************************************
  // bus and pin widths
  // ****************************************************************
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int PIN_N    = 27;
  localparam int GEN_N    = 6;

  // ****************************************************************
  // register indices and byte addresses (byte address is four times index)
  // ****************************************************************
  localparam logic [9:0]        IDX_DRIVE  = 10'h0bb;
  localparam logic [9:0]        IDX_LEVELS = 10'h0bc;
  localparam logic [ADDR_W-1:0] ADR_DRIVE  = {IDX_DRIVE, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_LEVELS = {IDX_LEVELS, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_PADCFG = 12'h400;

  // ****************************************************************
  // field layouts of the two pin-value registers
  // ****************************************************************
  // pins that software may drive (reserved 23, 11, 10 and 31..27 excluded)
  localparam logic [PIN_N-1:0] DRIVE_MASK  = 27'h77ff3ff;
  // pins whose level is reported (drivable pins plus test and straps)
  localparam logic [PIN_N-1:0] LEVEL_MASK  = 27'h7ffffff;
  // input-only pins: test pin 23, host select straps 11 and 10
  localparam logic [PIN_N-1:0] INONLY_MASK = 27'h0800c00;
  // host interface pins 7..4 reset high, everything else low
  localparam logic [PIN_N-1:0] DRIVE_RESET = 27'h00000f0;
  localparam logic [PIN_N-1:0] LEVEL_RESET = 27'h0000000;

  // bit position of each general pin: 0..3 then 19, 20
  localparam logic [4:0] GEN_POS [GEN_N] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h13, 5'h14};

  // ****************************************************************
  // pad config register of this block
  // ****************************************************************
  localparam int           CFG_OUTEN_LSB = 0;
  localparam int           CFG_INEN_LSB  = 8;
  localparam int           CFG_PWM_LSB   = 16;
  localparam logic [GEN_N-1:0] OUTEN_RESET = 6'h00;
  localparam logic [GEN_N-1:0] INEN_RESET  = 6'h3f;
  localparam logic [GEN_N-1:0] PWM_RESET   = 6'h00;

  // ****************************************************************
  // bus answers
  // ****************************************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // register selected by an address
  typedef enum logic [1:0] {
    SEL_NONE   = 2'b00,
    SEL_DRIVE  = 2'b01,
    SEL_LEVELS = 2'b10,
    SEL_PADCFG = 2'b11
  } pli_sel_type;

endpackage

/* src/pli_axil_slave.sv */
`timescale 1ns/10ps
// ****************************************************************
// axi4-lite slave front end: one write and one read in flight
// ****************************************************************
module pli_axil_slave
  import pli_pkg::*;
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // write address and data
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  // write response
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  // read address and data
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [DATA_W-1:0]      rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  // register side
  output logic                   wr_en_o,
  output logic [ADDR_W-1:0]      wr_addr_o,
  output logic [DATA_W-1:0]      wr_data_o,
  output logic [3:0]             wr_strb_o,
  input  wire logic              wr_ok_i,
  output logic [ADDR_W-1:0]      rd_addr_o,
  input  wire logic [DATA_W-1:0] rd_data_i,
  input  wire logic              rd_ok_i
);

  logic have_aw_q;
  logic have_w_q;
  logic have_ar_q;

  // ready only while the holding slot is empty and no answer waits
  assign awready_o = !have_aw_q && !bvalid_o;
  assign wready_o  = !have_w_q && !bvalid_o;
  assign arready_o = !have_ar_q && !rvalid_o;
  assign wr_en_o   = have_aw_q && have_w_q && !bvalid_o;

  // write address capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      have_aw_q <= 1'b0;
      wr_addr_o <= '0;
    end else if (awvalid_i && awready_o) begin
      have_aw_q <= 1'b1;
      wr_addr_o <= awaddr_i;
    end else if (wr_en_o) begin
      have_aw_q <= 1'b0;
    end
  end

  // write data capture, either order with the address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      have_w_q  <= 1'b0;
      wr_data_o <= '0;
      wr_strb_o <= '0;
    end else if (wvalid_i && wready_o) begin
      have_w_q  <= 1'b1;
      wr_data_o <= wdata_i;
      wr_strb_o <= wstrb_i;
    end else if (wr_en_o) begin
      have_w_q <= 1'b0;
    end
  end

  // write response one cycle after both halves are held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bvalid_o <= 1'b0;
      bresp_o  <= RESP_OKAY;
    end else if (wr_en_o) begin
      bvalid_o <= 1'b1;
      bresp_o  <= wr_ok_i ? RESP_OKAY : RESP_DECERR;
    end else if (bready_i) begin
      bvalid_o <= 1'b0;
    end
  end

  // read address capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      have_ar_q <= 1'b0;
      rd_addr_o <= '0;
    end else if (arvalid_i && arready_o) begin
      have_ar_q <= 1'b1;
      rd_addr_o <= araddr_i;
    end else if (have_ar_q) begin
      have_ar_q <= 1'b0;
    end
  end

  // read data registered the cycle after the address is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
      rresp_o  <= RESP_OKAY;
    end else if (have_ar_q) begin
      rvalid_o <= 1'b1;
      rdata_o  <= rd_ok_i ? rd_data_i : '0;
      rresp_o  <= rd_ok_i ? RESP_OKAY : RESP_DECERR;
    end else if (rready_i) begin
      rvalid_o <= 1'b0;
    end
  end

endmodule

/* src/pli_top.sv */
`timescale 1ns/10ps
// ****************************************************************
// pad level io registers
// ****************************************************************
// How it works
// - drive bit reaches pin while pin is output
// - level register read-only, follows input pins
// - general pins at bits 0-3, 19, 20
// - host interface pins 4-7, drive resets high
// - spi pins 13-16, i2c pins 17-18
// - card-side data, clock, interrupt at 24-26
// - auxiliary pins at bits 21, 22, 12
// - interrupt request bit 8, download request bit 9
// - test 23, straps 10-11 input only
// - other drive bits and levels reset zero
// - general drive needs output enable, resets off
// - general sampling needs input enable, resets on
// - pwm routing replaces drive bit on pin
module pli_top
  import pli_pkg::*;
(
  // clock and reset
  input  wire logic              REF_CLK_I,
  input  wire logic              RESET_I,
  // axi4-lite write channels
  input  wire logic [ADDR_W-1:0] AWADDR_I,
  input  wire logic              AWVALID_I,
  output logic                   AWREADY_O,
  input  wire logic [DATA_W-1:0] WDATA_I,
  input  wire logic [3:0]        WSTRB_I,
  input  wire logic              WVALID_I,
  output logic                   WREADY_O,
  output logic [1:0]             BRESP_O,
  output logic                   BVALID_O,
  input  wire logic              BREADY_I,
  // axi4-lite read channels
  input  wire logic [ADDR_W-1:0] ARADDR_I,
  input  wire logic              ARVALID_I,
  output logic                   ARREADY_O,
  output logic [DATA_W-1:0]      RDATA_O,
  output logic [1:0]             RRESP_O,
  output logic                   RVALID_O,
  input  wire logic              RREADY_I,
  // pads, bit order as in the pin-value registers
  input  wire logic [PIN_N-1:0]  PAD_IN_I,
  output logic [PIN_N-1:0]       PAD_OUT_O,
  output logic [PIN_N-1:0]       PAD_OE_O,
  // direction of the non-general pins from their own peripherals
  input  wire logic [PIN_N-1:0]  PIN_IS_OUTPUT_I,
  // pwm unit outputs, one per general pin
  input  wire logic [GEN_N-1:0]  PWM_I
);

  // ****************************************************************
  // functions
  // ****************************************************************

  // address to register select, low two bits ignored
  function automatic pli_sel_type decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] word;
    word = {addr[ADDR_W-1:2], 2'b00};
    if (word == ADR_DRIVE) begin
      decode = SEL_DRIVE;
    end else if (word == ADR_LEVELS) begin
      decode = SEL_LEVELS;
    end else if (word == ADR_PADCFG) begin
      decode = SEL_PADCFG;
    end else begin
      decode = SEL_NONE;
    end
  endfunction

  // byte-lane merge of write data into a stored word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old,
                                              input logic [DATA_W-1:0] data,
                                              input logic [3:0]        strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    merge = res;
  endfunction

  // ****************************************************************
  // bus front end
  // ****************************************************************
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [DATA_W-1:0] rd_data;
  logic              rd_ok;
  pli_sel_type       wr_sel;
  pli_sel_type       rd_sel;

  pli_axil_slave u_bus (
    .clk_i     (REF_CLK_I),
    .rst_i     (RESET_I),
    .awaddr_i  (AWADDR_I),
    .awvalid_i (AWVALID_I),
    .awready_o (AWREADY_O),
    .wdata_i   (WDATA_I),
    .wstrb_i   (WSTRB_I),
    .wvalid_i  (WVALID_I),
    .wready_o  (WREADY_O),
    .bresp_o   (BRESP_O),
    .bvalid_o  (BVALID_O),
    .bready_i  (BREADY_I),
    .araddr_i  (ARADDR_I),
    .arvalid_i (ARVALID_I),
    .arready_o (ARREADY_O),
    .rdata_o   (RDATA_O),
    .rresp_o   (RRESP_O),
    .rvalid_o  (RVALID_O),
    .rready_i  (RREADY_I),
    .wr_en_o   (wr_en),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_strb_o (wr_strb),
    .wr_ok_i   (wr_ok),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_ok_i   (rd_ok)
  );

  assign wr_sel = decode(wr_addr);
  assign rd_sel = decode(rd_addr);
  // writes to the level register are accepted but change nothing
  assign wr_ok  = (wr_sel != SEL_NONE);
  assign rd_ok  = (rd_sel != SEL_NONE);

  // ****************************************************************
  // stored state
  // ****************************************************************
  logic [PIN_N-1:0] drive_q;
  logic [PIN_N-1:0] levels_q;
  logic [GEN_N-1:0] out_en_q;
  logic [GEN_N-1:0] in_en_q;
  logic [GEN_N-1:0] pwm_sel_q;
  logic [PIN_N-1:0] oe_d;
  logic [PIN_N-1:0] out_d;
  logic [PIN_N-1:0] sample_d;
  logic [DATA_W-1:0] drive_wr;
  logic [DATA_W-1:0] cfg_rd;
  logic [DATA_W-1:0] cfg_wr;

  // drive register image after a byte-lane merge
  assign drive_wr = merge({{(DATA_W-PIN_N){1'b0}}, drive_q}, wr_data, wr_strb);

  // pad config image: output enables, input enables, pwm routing
  always_comb begin
    cfg_rd = '0;
    cfg_rd[CFG_OUTEN_LSB +: GEN_N] = out_en_q;
    cfg_rd[CFG_INEN_LSB +: GEN_N]  = in_en_q;
    cfg_rd[CFG_PWM_LSB +: GEN_N]   = pwm_sel_q;
  end
  assign cfg_wr = merge(cfg_rd, wr_data, wr_strb);

  // drive values; reserved positions are masked so they never store
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      drive_q <= DRIVE_RESET;
    end else if (wr_en && wr_sel == SEL_DRIVE) begin
      drive_q <= drive_wr[PIN_N-1:0] & DRIVE_MASK;
    end
  end

  // per general pin enables and pwm routing
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      out_en_q  <= OUTEN_RESET;
      in_en_q   <= INEN_RESET;
      pwm_sel_q <= PWM_RESET;
    end else if (wr_en && wr_sel == SEL_PADCFG) begin
      out_en_q  <= cfg_wr[CFG_OUTEN_LSB +: GEN_N];
      in_en_q   <= cfg_wr[CFG_INEN_LSB +: GEN_N];
      pwm_sel_q <= cfg_wr[CFG_PWM_LSB +: GEN_N];
    end
  end

  // ****************************************************************
  // pin direction, value and sampling
  // ****************************************************************

  // non-general pins follow their peripheral's direction; general pins
  // are overridden below by their own enable
  always_comb begin
    oe_d     = PIN_IS_OUTPUT_I & DRIVE_MASK;
    out_d    = drive_q;
    sample_d = ~oe_d & LEVEL_MASK;
    for (int k = 0; k < GEN_N; k++) begin
      oe_d[GEN_POS[k]]     = out_en_q[k];
      out_d[GEN_POS[k]]    = pwm_sel_q[k] ? PWM_I[k] : drive_q[GEN_POS[k]];
      sample_d[GEN_POS[k]] = in_en_q[k] && !out_en_q[k];
    end
    // test pin and straps are never driven and always reported
    oe_d     = oe_d & ~INONLY_MASK;
    sample_d = sample_d | INONLY_MASK;
  end

  // pad outputs straight from flip-flops; one cycle of latency is the
  // price of a clean, glitch-free pad drive
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      // no pad is an output in reset, so its drive value must read zero too
      PAD_OE_O  <= '0;
      PAD_OUT_O <= '0;
    end else begin
      PAD_OE_O  <= oe_d;
      PAD_OUT_O <= out_d & oe_d;
    end
  end

  // level sampling; a pin not sampled keeps its last captured level
  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      levels_q <= LEVEL_RESET;
    end else begin
      for (int i = 0; i < PIN_N; i++) begin
        if (sample_d[i]) begin
          levels_q[i] <= PAD_IN_I[i];
        end
      end
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************

  // bits above the pin field always read zero
  always_comb begin
    rd_data = '0;
    case (rd_sel)
      SEL_DRIVE: begin
        rd_data[PIN_N-1:0] = drive_q;
      end
      SEL_LEVELS: begin
        rd_data[PIN_N-1:0] = levels_q & LEVEL_MASK;
      end
      SEL_PADCFG: begin
        rd_data = cfg_rd;
      end
      default: begin
        rd_data = '0;
      end
    endcase
  end

endmodule

/* testbench/pli_top_checker.sv */
`timescale 1ns/10ps
// ****************************************************************
// port checker for the pad level registers
// ****************************************************************
module pli_top_checker
  import pli_pkg::*;
(
  // clock and reset
  input wire logic             REF_CLK_I,
  input wire logic             RESET_I,
  // bus handshakes and answers
  input wire logic             AWVALID_I,
  input wire logic             AWREADY_O,
  input wire logic             WVALID_I,
  input wire logic             WREADY_O,
  input wire logic [1:0]       BRESP_O,
  input wire logic             BVALID_O,
  input wire logic             BREADY_I,
  input wire logic             ARVALID_I,
  input wire logic             ARREADY_O,
  input wire logic [DATA_W-1:0] RDATA_O,
  input wire logic [1:0]       RRESP_O,
  input wire logic             RVALID_O,
  input wire logic             RREADY_I,
  // pads
  input wire logic [PIN_N-1:0] PAD_OUT_O,
  input wire logic [PIN_N-1:0] PAD_OE_O,
  input wire logic [PIN_N-1:0] PIN_IS_OUTPUT_I
);
  // drivable pins whose direction comes from their own peripheral
  localparam logic [PIN_N-1:0] NONGEN = 27'h767f3f0;

  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);

  chk_write_answer: assert property (
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##1 !BVALID_O ##1 BVALID_O)
    else $error("write answer not two cycles after acceptance");
  chk_read_answer: assert property (
    ARVALID_I && ARREADY_O |-> ##1 !RVALID_O ##1 RVALID_O)
    else $error("read answer not two cycles after acceptance");
  chk_bresp_hold: assert property (
    BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write answer dropped before taken");
  chk_rdata_hold: assert property (
    RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O) && $stable(RRESP_O))
    else $error("read answer dropped before taken");
  chk_addr_busy: assert property (
    AWVALID_I && AWREADY_O |=> !AWREADY_O [*2])
    else $error("second write address taken too early");
  chk_input_only: assert property (
    (PAD_OE_O & INONLY_MASK) == '0)
    else $error("input only pin driven");
  chk_out_gated: assert property (
    (PAD_OUT_O & ~PAD_OE_O) == '0)
    else $error("drive value on a pin that is not an output");
  chk_dir_follow: assert property (
    !$past(RESET_I) |-> (PAD_OE_O & NONGEN) == ($past(PIN_IS_OUTPUT_I) & NONGEN))
    else $error("pad enable does not follow pin direction");
  chk_reset_pads: assert property (
    $past(RESET_I) |-> PAD_OE_O == '0 && PAD_OUT_O == '0 && !BVALID_O && !RVALID_O)
    else $error("pads or answers active out of reset");
endmodule

/* testbench/pli_pin_board.sv */
`timescale 1ns/10ps
// ****************************************************************
// board model standing on the pads
// ****************************************************************
module pli_pin_board
  import pli_pkg::*;
(
  // clock
  input  wire logic             clk_i,
  // what the device drives
  input  wire logic [PIN_N-1:0] pad_out_i,
  input  wire logic [PIN_N-1:0] pad_oe_i,
  // what the board drives
  input  wire logic [PIN_N-1:0] ext_en_i,
  input  wire logic [PIN_N-1:0] ext_val_i,
  // level at the pads
  output logic      [PIN_N-1:0] pad_in_o
);
  logic [PIN_N-1:0] float_q = '0;

  // undriven pads wander, so a stale capture never looks right by luck
  always @(posedge clk_i) begin
    float_q <= ~float_q;
  end

  // device wins where it drives, then the board, else the floating level
  assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
                  | (~pad_oe_i & ~ext_en_i & float_q);
endmodule

/* testbench/pli_tb_top.sv */
`timescale 1ns/10ps
// ****************************************************************
// bench for the pad level registers
// ****************************************************************
module pli_tb_top
  import pli_pkg::*;
;
  localparam int          GP [6] = '{0, 1, 2, 3, 19, 20};
  localparam logic [26:0] DRV    = 27'h77ff3ff;
  logic        clk, rst, awv, wv, bry, arv, rry, awr, wr, bv, arr, rv;
  logic [11:0] awa, ara;
  logic [31:0] wd, rd;
  logic [3:0]  ws;
  logic [1:0]  br, rr;
  logic [26:0] pin, pout, poe, dir, ext, m_drv, m_lvl;
  logic [31:0] m_cfg;
  logic [5:0]  pwm;
  int          miscompares, compares;

  pli_top u_pli_top (.REF_CLK_I(clk), .RESET_I(rst), .AWADDR_I(awa), .AWVALID_I(awv),
    .AWREADY_O(awr), .WDATA_I(wd), .WSTRB_I(ws), .WVALID_I(wv), .WREADY_O(wr),
    .BRESP_O(br), .BVALID_O(bv), .BREADY_I(bry), .ARADDR_I(ara), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rd), .RRESP_O(rr), .RVALID_O(rv), .RREADY_I(rry),
    .PAD_IN_I(pin), .PAD_OUT_O(pout), .PAD_OE_O(poe), .PIN_IS_OUTPUT_I(dir), .PWM_I(pwm));
  pli_pin_board u_pli_pin_board (.clk_i(clk), .pad_out_i(pout), .pad_oe_i(poe),
    .ext_en_i({PIN_N{1'b1}}), .ext_val_i(ext), .pad_in_o(pin));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // spread a general-pin field onto its pin positions
  function automatic logic [26:0] gen(input logic [5:0] v);
    logic [26:0] r;
    r = '0;
    for (int k = 0; k < 6; k++) r[GP[k]] = v[k];
    return r;
  endfunction

  // byte lanes of a write land only where strobed
  function automatic logic [31:0] mrg(input logic [31:0] o, d, input logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) o[8*b+:8] = d[8*b+:8];
    return o;
  endfunction

  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] e);
    logic pa, pw;
    pa = 1'b1;
    pw = 1'b1;
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (awr) pa = 1'b0;
      if (wr) pw = 1'b0;
      awv <= pa;
      wv <= pw;
    end
    // a slow master stalls the answer for a while
    repeat ($urandom_range(2)) @(posedge clk);
    bry <= 1'b1;
    do @(posedge clk); while (bv !== 1'b1);
    bry <= 1'b0;
    chk("bresp", 32'(br), 32'(e));
  endtask

  task automatic axr(input logic [11:0] a, input logic [31:0] x, input logic [1:0] e,
                     input string nm);
    ara <= a;
    arv <= 1'b1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 1'b0;
    repeat ($urandom_range(2)) @(posedge clk);
    rry <= 1'b1;
    do @(posedge clk); while (rv !== 1'b1);
    rry <= 1'b0;
    chk(nm, rd, x);
    chk("rresp", 32'(rr), 32'(e));
  endtask

  // let changes reach the pads, then compare pads and advance the level model
  task automatic settle();
    logic [26:0] oe, sel, smp;
    repeat (3) @(posedge clk);
    sel = gen(m_cfg[21:16]);
    oe = (dir & DRV & ~gen(6'h3f)) | gen(m_cfg[5:0]);
    smp = ~DRV | (~dir & DRV & ~gen(6'h3f)) | gen(m_cfg[13:8] & ~m_cfg[5:0]);
    m_lvl = (m_lvl & ~smp) | (ext & smp);
    chk("pad_oe", 32'(poe), 32'(oe));
    chk("pad_out", 32'(pout), 32'(oe & ((m_drv & ~sel) | (gen(pwm) & sel))));
  endtask

  task automatic finish_test();
    if (miscompares == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // hang guard, some fifteen to twenty times the expected run
  initial begin
    #100us;
    miscompares++;
    finish_test();
  end

  // main sequence: drive 0x2ec, levels 0x2f0, pad config 0x400, 0x2f4 unmapped
  initial begin
    logic [31:0] v;
    logic [3:0]  st;
    {awv, wv, bry, arv, rry, awa, ara, wd, ws} = '0;
    {dir, pwm, ext, m_lvl} = '0;
    rst = 1'b1;
    m_drv = 27'h00000f0;
    m_cfg = 32'h3f00;
    miscompares = 0;
    compares = 0;
    void'($urandom(32'hafae));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    axr(12'h2ec, 32'h00000f0, 2'h0, "drive_reset");
    axr(12'h2f0, 32'h0, 2'h0, "level_reset");
    axr(12'h400, 32'h3f00, 2'h0, "cfg_reset");
    settle();
    axw(12'h2ec, 32'hffffffff, 4'hf, 2'h0);
    m_drv = DRV;
    axr(12'h2ec, 32'(DRV), 2'h0, "drive_mask");
    axw(12'h2f0, 32'hffffffff, 4'hf, 2'h0);
    axw(12'h2f4, 32'hffffffff, 4'hf, 2'h3);
    axr(12'h2f4, 32'h0, 2'h3, "unmapped");
    for (int i = 0; i < 24; i++) begin
      dir <= 27'($urandom);
      pwm <= 6'($urandom);
      ext <= 27'($urandom);
      settle();
      axr(12'h2f0, 32'(m_lvl), 2'h0, "levels");
      v = $urandom;
      st = (i % 3 != 0) ? 4'hf : 4'($urandom);
      axw(12'h2ec, v, st, 2'h0);
      m_drv = 27'(mrg(32'(m_drv), v, st)) & DRV;
      axr(12'h2ec, 32'(m_drv), 2'h0, "drive");
      v = $urandom;
      axw(12'h400, v, 4'hf, 2'h0);
      m_cfg = v & 32'h3f3f3f;
      axr(12'h400, m_cfg, 2'h0, "cfg");
      settle();
    end
    finish_test();
  end
endmodule

bind pli_top pli_top_checker u_pli_top_checker (.REF_CLK_I(REF_CLK_I), .RESET_I(RESET_I),
  .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
  .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
  .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O), .RRESP_O(RRESP_O), .RVALID_O(RVALID_O),
  .RREADY_I(RREADY_I), .PAD_OUT_O(PAD_OUT_O), .PAD_OE_O(PAD_OE_O),
  .PIN_IS_OUTPUT_I(PIN_IS_OUTPUT_I));
